// *** design/rrsx_core.sv ***
// What this block does
// - A return word pops the stack and loads the popped top into the program counter, leaving the flags alone.
// - A return takes two cycles, and the word offered in the second cycle is discarded.
// - A rotate-right word shifts the operand right through carry, old carry into bit 7 and bit 0 into carry.
// - The rotate destination bit sends the result to the accumulator when 0 or back to the file register when 1.
// - A literal-subtract word writes the literal minus the accumulator into the accumulator, ignoring bit 8.
// - The literal-subtract sets the borrow-inverse flag when the result is zero or positive and clears it otherwise.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rrsx_core
   import rrsx_pkg::*;
#(
   parameter int PC_W = 13
) (
   input  wire logic                  clock_i,
   input  wire logic                  reset_i,
   input  wire logic                  instr_valid_i,
   input  wire logic [INSTR_W-1:0]    instr_i,
   input  wire logic [DATA_W-1:0]     file_rdata_i,
   input  wire logic [PC_W-1:0]       stack_top_i,
   input  wire logic [REG_ADDR_W-1:0] reg_addr_i,
   input  wire logic [DATA_W-1:0]     reg_wdata_i,
   input  wire logic                  reg_write_i,
   input  wire logic                  reg_read_i,
   output var  logic [DATA_W-1:0]     reg_rdata_o,
   output var  logic                  stack_pop_o,
   output var  logic                  pc_load_o,
   output var  logic [PC_W-1:0]       program_counter_o,
   output var  logic                  flush_o,
   output var  rrsx_fwrite_t          file_write_o,
   output var  logic [DATA_W-1:0]     acc_o,
   output var  rrsx_flags_t           flags_o
);

   initial begin
      // The PC read-back returns the low byte, so PC_W must cover it.
      if (PC_W < DATA_W || PC_W > DATA_W * 2) begin
         $error("rrsx_core: PC_W out of range");
      end
      if (FLAG_W > DATA_W) begin
         $error("rrsx_core: flags do not fit the data width");
      end
      if (FADDR_W > DEST_BIT) begin
         $error("rrsx_core: file address overlaps the destination bit");
      end
      if (NIB_HI >= DATA_W) begin
         $error("rrsx_core: half-carry boundary outside the data word");
      end
      if (MSB_BIT != DATA_W - 1) begin
         $error("rrsx_core: rotate entry bit is not the top bit");
      end
   end

   // Read decode of the software port; unmapped addresses return zero.
   function automatic logic [DATA_W-1:0] read_mux(
      input logic [REG_ADDR_W-1:0] a,
      input logic [DATA_W-1:0]     acc,
      input rrsx_flags_t           fl,
      input logic [PC_W-1:0]       pc
   );
      case (a)
         REG_ACC:    read_mux = acc;
         REG_STATUS: read_mux = DATA_W'(fl);
         REG_PC:     read_mux = pc[DATA_W-1:0];
         default:    read_mux = '0;
      endcase
   endfunction

   function automatic logic op_match(input logic [INSTR_W-1:0] w,
                                     input logic [INSTR_W-1:0] mask,
                                     input logic [INSTR_W-1:0] match);
      op_match = (w & mask) == match;
   endfunction

   rrsx_state_t          state_q, state_d;
   logic [DATA_W-1:0]    acc_q, acc_d;
   rrsx_flags_t          flags_q, flags_d;
   logic [PC_W-1:0]      pc_q, pc_d;
   logic                 pop_q, pop_d;
   logic                 load_q, load_d;
   logic                 flush_q, flush_d;
   rrsx_fwrite_t         fw_q, fw_d;
   logic [DATA_W-1:0]    rdata_q, rdata_d;

   logic                 live;
   logic                 is_ret;
   logic                 is_rrf;
   logic                 is_sub;
   logic [DATA_W-1:0]    lit;
   logic [DATA_W-1:0]    rot;
   logic [DATA_W-1:0]    diff;

   always_comb begin
      live    = instr_valid_i && (state_q == ST_EXEC);
      is_ret  = live && op_match(instr_i, RET_MASK, RET_MATCH);
      is_rrf  = live && op_match(instr_i, RRF_MASK, RRF_MATCH);
      is_sub  = live && op_match(instr_i, SUB_MASK, SUB_MATCH);
      lit     = instr_i[DATA_W-1:0];
      rot     = {flags_q.borrow_inverse,
                 file_rdata_i[DATA_W-1:1]};
      diff    = lit - acc_q;

      state_d = state_q;
      acc_d   = acc_q;
      flags_d = flags_q;
      pc_d    = pc_q;
      pop_d   = 1'b0;
      load_d  = 1'b0;
      flush_d = 1'b0;
      fw_d    = '{1'b0, fw_q.addr, fw_q.data};

      // Software writes lose to an instruction in the same cycle only in the register fields that the instruction itself writes.
      if (reg_write_i) begin
         case (reg_addr_i)
            REG_ACC:    acc_d   = reg_wdata_i;
            REG_STATUS: flags_d = rrsx_flags_t'(reg_wdata_i[FLAG_W-1:0]);
            default:    acc_d   = acc_q;
         endcase
      end

      case (state_q)
         ST_EXEC: begin
            if (is_ret) begin
               pc_d    = stack_top_i;
               pop_d   = 1'b1;
               load_d  = 1'b1;
               flush_d = 1'b1;
               state_d = ST_FLUSH;
            end else if (is_rrf) begin
               flags_d.borrow_inverse = file_rdata_i[0];
               if (instr_i[DEST_BIT]) begin
                  fw_d = '{1'b1, instr_i[FADDR_W-1:0], rot};
               end else begin
                  acc_d = rot;
               end
            end else if (is_sub) begin
               acc_d                  = diff;
               flags_d.borrow_inverse = lit >= acc_q;
               flags_d.half_carry     =
                  lit[NIB_HI:0] >= acc_q[NIB_HI:0];
               flags_d.null_result    = diff == '0;
            end
         end
         ST_FLUSH: begin
            state_d = ST_EXEC;
         end
         default: begin
            state_d = ST_EXEC;
         end
      endcase
   end

   // Read data stand for exactly the cycle after the read strobe.
   always_comb begin
      rdata_d = '0;
      if (reg_read_i) begin
         rdata_d = read_mux(reg_addr_i, acc_q, flags_q, pc_q);
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= ST_EXEC;
         acc_q   <= ACC_RESET;
         flags_q <= FLAGS_RESET;
         pc_q    <= '0;
         pop_q   <= 1'b0;
         load_q  <= 1'b0;
         flush_q <= 1'b0;
         fw_q    <= '0;
      end else begin
         state_q <= state_d;
         acc_q   <= acc_d;
         flags_q <= flags_d;
         pc_q    <= pc_d;
         pop_q   <= pop_d;
         load_q  <= load_d;
         flush_q <= flush_d;
         fw_q    <= fw_d;
      end
   end

   // Every output is a plain copy of its register.
   always_comb begin
      reg_rdata_o       = rdata_q;
      stack_pop_o       = pop_q;
      pc_load_o         = load_q;
      program_counter_o = pc_q;
      flush_o           = flush_q;
      file_write_o      = fw_q;
      acc_o             = acc_q;
      flags_o           = flags_q;
   end

endmodule
`default_nettype wire

// *** pkg/rrsx_pkg.sv ***
package rrsx_pkg;

   localparam int          INSTR_W      = 14;
   localparam int          DATA_W       = 8;
   localparam int          FADDR_W      = 7;
   localparam int          REG_ADDR_W   = 2;

   // Decode patterns as mask and match pairs over the 14-bit word.
   localparam logic [13:0] RET_MASK     = 14'h3FFF;
   localparam logic [13:0] RET_MATCH    = 14'h0008;
   localparam logic [13:0] RRF_MASK     = 14'h3F00;
   localparam logic [13:0] RRF_MATCH    = 14'h0C00;
   localparam logic [13:0] SUB_MASK     = 14'h3E00;
   localparam logic [13:0] SUB_MATCH    = 14'h3C00;
   localparam int          DEST_BIT     = 7;
   localparam int          MSB_BIT      = 7;
   localparam int          NIB_HI       = 3;

   // Register map of the software port.
   localparam logic [1:0]  REG_ACC      = 2'h0;
   localparam logic [1:0]  REG_STATUS   = 2'h1;
   localparam logic [1:0]  REG_PC       = 2'h2;
   localparam logic [7:0]  ACC_RESET    = 8'h00;
   localparam int          FLAG_W       = 3;

   typedef struct packed {
      logic null_result;
      logic half_carry;
      logic borrow_inverse;
   } rrsx_flags_t;

   localparam rrsx_flags_t FLAGS_RESET  = '{1'b0, 1'b0, 1'b0};

   typedef struct packed {
      logic                 we;
      logic [FADDR_W-1:0]   addr;
      logic [DATA_W-1:0]    data;
   } rrsx_fwrite_t;

   typedef enum logic [0:0] {
      ST_EXEC,
      ST_FLUSH
   } rrsx_state_t;

endpackage

// *** sim/rrsx_core_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module rrsx_core_properties
   import rrsx_pkg::*;
#(parameter int PC_W = 13) (
   input wire logic            clock_i,
   input wire logic            reset_i,
   input wire logic            instr_valid_i,
   input wire logic [13:0]     instr_i,
   input wire logic [7:0]      file_rdata_i,
   input wire logic [PC_W-1:0] stack_top_i,
   input wire logic            stack_pop_o,
   input wire logic            pc_load_o,
   input wire logic [PC_W-1:0] program_counter_o,
   input wire logic            flush_o,
   input wire rrsx_fwrite_t    file_write_o,
   input wire logic [7:0]      acc_o,
   input wire rrsx_flags_t     flags_o
);
   wire logic t = instr_valid_i && !flush_o;
   wire logic ret = t && instr_i == RET_MATCH;
   wire logic rot = t && (instr_i & RRF_MASK) == RRF_MATCH;
   wire logic sub = t && (instr_i & SUB_MASK) == SUB_MATCH;
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   ret_pulse_a: assert property (ret |=> stack_pop_o && pc_load_o && flush_o)
      else $error("return pulses missing");
   flush_once_a: assert property (flush_o |=> !flush_o)
      else $error("flush longer than one cycle");
   ret_pc_a: assert property (ret |=> program_counter_o == $past(stack_top_i))
      else $error("program counter not loaded");
   ret_flags_a: assert property (ret |=> $stable(flags_o))
      else $error("return changed flags");
   rot_carry_a: assert property (rot |=> flags_o.borrow_inverse == $past(file_rdata_i[0]))
      else $error("rotate carry wrong");
   rot_back_a: assert property (rot && instr_i[7] |=> file_write_o.we && file_write_o.data == {$past(flags_o.borrow_inverse), $past(file_rdata_i[7:1])})
      else $error("rotate write back wrong");
   rot_acc_a: assert property (rot && !instr_i[7] |=> !file_write_o.we && acc_o == {$past(flags_o.borrow_inverse), $past(file_rdata_i[7:1])})
      else $error("rotate to accumulator wrong");
   sub_acc_a: assert property (sub |=> acc_o == 8'($past(instr_i[7:0]) - $past(acc_o)))
      else $error("subtract result wrong");
   sub_borrow_a: assert property (sub |=> flags_o.borrow_inverse == ($past(instr_i[7:0]) >= $past(acc_o)))
      else $error("borrow flag wrong");
   rot_keep_a: assert property (rot |=> flags_o.null_result == $past(flags_o.null_result) && flags_o.half_carry == $past(flags_o.half_carry))
      else $error("rotate changed other flags");
endmodule
`default_nettype wire

// *** sim/test_return_rotate_subtract_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_return_rotate_subtract_exec;
   import rrsx_pkg::*;
   logic clock_i = 0, reset_i = 1, instr_valid_i = 0, reg_write_i = 0;
   logic reg_read_i = 0, stack_pop_o, pc_load_o, flush_o, z = 0, dc = 0, c = 0;
   logic [13:0] instr_i = '0;
   logic [7:0] file_rdata_i = '0, reg_wdata_i = '0, reg_rdata_o, acc_o, acc = 0;
   logic [12:0] stack_top_i = '0, program_counter_o, pc = 0;
   logic [1:0] reg_addr_i = '0;
   rrsx_fwrite_t file_write_o;
   rrsx_flags_t flags_o;
   int error_cnt = 0, n_tests = 0;
   logic [31:0] seed = 32'h00006351;
   rrsx_core dut_u (.*);
   initial forever #10 clock_i = ~clock_i;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input logic [15:0] g, e);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task issue(input logic [13:0] w);
      logic [7:0] rd, r;
      logic [12:0] st;
      rd = 8'(rnd());
      st = 13'(rnd());
      r = {c, rd[7:1]};
      @(posedge clock_i);
      instr_valid_i <= 1;
      instr_i <= w;
      file_rdata_i <= rd;
      stack_top_i <= st;
      @(posedge clock_i);
      instr_valid_i <= (w == 14'h0008);
      instr_i <= 14'h3C55;
      #1;
      if (w == 14'h0008) pc = st;
      if (w[13:9] == 5'h1E) begin
         dc = w[3:0] >= acc[3:0];
         c = w[7:0] >= acc;
         acc = w[7:0] - acc;
         z = acc == 0;
      end
      if (w[13:8] == 6'h0C) begin
         chk(file_write_o.we, w[7]);
         c = rd[0];
         if (w[7]) chk(file_write_o.data, r);
         if (w[7]) chk(file_write_o.addr, w[6:0]);
         else acc = r;
      end
      chk({stack_pop_o, pc_load_o, flush_o}, {3{w == 14'h0008}});
      chk(program_counter_o, pc);
      chk(acc_o, acc);
      chk(flags_o, {z, dc, c});
   endtask
   task regx(input logic wr, input logic [1:0] a, input logic [7:0] d, e);
      @(posedge clock_i);
      instr_valid_i <= 0;
      reg_write_i <= wr;
      reg_read_i <= !wr;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_write_i <= 0;
      reg_read_i <= 0;
      #1;
      if (!wr) chk(reg_rdata_o, e);
      else if (a == 0) acc = d;
      else if (a == 1) {z, dc, c} = d[2:0];
   endtask
   initial begin
      logic [31:0] s;
      repeat (10) @(posedge clock_i);
      reset_i <= 0;
      regx(1, 0, 8'h02, 0);
      issue(14'h3D02);
      issue(14'h3FFF);
      for (int i = 0; i < 60; i++) begin
         s = rnd();
         case (s % 5)
            0: issue(14'h0008);
            1: issue({6'h0C, s[15:8]});
            2: issue({5'h1E, s[16:8]});
            3: regx(1, s[9:8], s[23:16], 0);
            default: regx(0, s[9:8], 0, s[9:8] == 0 ? acc : s[9:8] == 1 ?
               {5'h00, z, dc, c} : s[9:8] == 2 ? pc[7:0] : 8'h00);
         endcase
      end
      $display("random sequence done");
      end_sim;
   end
   initial begin
      #100000;
      error_cnt++;
      end_sim;
   end
endmodule
bind rrsx_core rrsx_core_properties #(.PC_W(PC_W)) chk_u (.*);
`default_nettype wire
